/* File: logic/srw_pkg.sv */
package srw_pkg;
    // Octet geometry
    localparam int OCT_W   = 8;
    localparam int REQ_OCT = 4;
    localparam int STA_OCT = 8;

    // Request octet 0 bit positions
    localparam int RQ_SPD_B   = 0;
    localparam int RQ_SPD_A   = 1;
    localparam int RQ_CSTOP   = 4;
    localparam int RQ_ESTOP   = 5;
    localparam int RQ_STARTP  = 6;
    localparam int RQ_TOFF    = 7;
    // Request octet 1 bit positions, counted over the whole word
    localparam int RQ_NEG_DIR = 8;
    localparam int RQ_POS_DIR = 9;
    localparam int RQ_SPD_D   = 14;
    localparam int RQ_SPD_C   = 15;
    // Request octet 2 bit positions, counted over the whole word
    localparam int RQ_VAR     = 16;
    localparam int RQ_ACK     = 18;
    localparam int RQ_MON_D   = 20;
    localparam int RQ_MON_C   = 21;
    localparam int RQ_MON_B   = 22;
    localparam int RQ_MON_A   = 23;
    // Request octet 3 bit positions, counted over the whole word
    localparam int RQ_OUT_LSB = 24;
    localparam int SAFE_OUT_N = 6;
    localparam int RQ_NEG_SCL = 30;
    localparam int RQ_POS_SCL = 31;

    // Function bits of octets 0..2 (acknowledge excluded) and reserved bits
    localparam int          FN_W     = 24;
    localparam logic [23:0] FN_MASK  = 24'hF1C3F3;
    localparam logic [31:0] RSV_MASK = 32'h000A3C0C;
    localparam logic [23:0] CFG_RST  = FN_MASK;

    // Status layout
    localparam logic [7:0]  ST0_RSV  = 8'h0C;
    localparam int          ST_MOD_OCT = 5;
    localparam int          ST_MOD_BIT = 7;
    localparam int          ST_SPD_HI  = 6;
    localparam int          ST_SPD_LO  = 7;

    // Register byte addresses
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_REQ   = 8'h04;
    localparam logic [7:0] A_LIMIT = 8'h08;
    localparam logic [7:0] A_CFG   = 8'h0C;
    localparam logic [7:0] A_ACT   = 8'h10;
    localparam logic [7:0] A_STLO  = 8'h14;
    localparam logic [7:0] A_STHI  = 8'h18;
    localparam logic [7:0] A_ISTAT = 8'h1C;
    localparam logic [7:0] A_IMASK = 8'h20;

    // Control register fields
    localparam int C_ACCEPT = 0;
    localparam int C_FAILS  = 1;
    localparam int C_CONFIG = 2;

    // Interrupt status fields
    localparam int IRQ_W    = 3;
    localparam int I_ACCEPT = 0;
    localparam int I_CFGF   = 1;
    localparam int I_RSV    = 2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* File: logic/srw_req_if.sv */
`timescale 1ns/1ps
interface srw_req_if;
    import srw_pkg::*;
    logic [31:0] req_word;
    logic [15:0] limit_word;
    logic [23:0] fn_req;
    logic [5:0]  safe_out;
    logic        neg_unscaled;
    logic        pos_unscaled;
    logic [15:0] limit;
    logic        rsv_hit;

    modport dec (
        input  req_word, limit_word,
        output fn_req, safe_out, neg_unscaled, pos_unscaled, limit, rsv_hit
    );
    modport top (
        output req_word, limit_word,
        input  fn_req, safe_out, neg_unscaled, pos_unscaled, limit, rsv_hit
    );
endinterface

/* File: logic/srw_req_decode.sv */
`timescale 1ns/1ps
module srw_req_decode
    import srw_pkg::*;
(
    srw_req_if.dec rq
);
    // Split the request word into function bits, outputs and scaling
    always_comb begin
        rq.fn_req       = rq.req_word[FN_W-1:0] & FN_MASK;
        rq.safe_out     = rq.req_word[RQ_OUT_LSB +: SAFE_OUT_N];
        rq.neg_unscaled = rq.req_word[RQ_NEG_SCL];
        rq.pos_unscaled = rq.req_word[RQ_POS_SCL];
        rq.rsv_hit      = |(rq.req_word & RSV_MASK);
        // High byte from octet 4, low byte from octet 5
        rq.limit = {rq.limit_word[OCT_W-1:0],
                    rq.limit_word[OCT_W +: OCT_W]};
    end
endmodule

/* File: logic/srw_stat_encode.sv */
`timescale 1ns/1ps
module srw_stat_encode
    import srw_pkg::*;
(
    input  wire logic [47:0] status_core,
    input  wire logic        modulating,
    input  wire logic [15:0] safe_speed,
    input  wire logic        zero_all,
    output logic      [63:0] status_data
);
    logic [63:0] raw;

    // Assemble octets 0..7, octet n at bits 8n+7..8n
    always_comb begin
        raw = {safe_speed[OCT_W-1:0], safe_speed[OCT_W +: OCT_W],
               status_core};
        raw[OCT_W-1:0] = status_core[OCT_W-1:0] & ~ST0_RSV;
        raw[ST_MOD_OCT*OCT_W + ST_MOD_BIT] = modulating;
        status_data = zero_all ? '0 : raw;
    end
endmodule

/* File: logic/srw_decoder_top.sv */
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module srw_decoder_top
    import srw_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [47:0] status_core,
    input  wire logic        modulating,
    input  wire logic [15:0] safe_speed,
    output logic             speed_limit_a_req,
    output logic             speed_limit_b_req,
    output logic             speed_limit_c_req,
    output logic             speed_limit_d_req,
    output logic             controlled_stop_req,
    output logic             emergency_stop_req,
    output logic             start_prevention_req,
    output logic             torque_off_req,
    output logic             neg_direction_lock_req,
    output logic             pos_direction_lock_req,
    output logic             function_end_ack,
    output logic             speed_monitor_a_req,
    output logic             speed_monitor_b_req,
    output logic             speed_monitor_c_req,
    output logic             speed_monitor_d_req,
    output logic             variable_limit_req,
    output logic      [15:0] variable_limit,
    output logic      [5:0]  safe_out_ctrl,
    output logic             neg_unscaled,
    output logic             pos_unscaled,
    output logic             config_fault,
    output logic      [63:0] status_data,
    output logic             irq
);
    srw_req_if rq ();

    // Bus address phase capture
    logic        ap_wr_ff;
    logic [7:0]  ap_addr_ff;
    logic        nxt_ap_wr;
    logic [7:0]  nxt_ap_addr;

    // Software registers
    logic [31:0] req_ff,   nxt_req;
    logic [15:0] lim_ff,   nxt_lim;
    logic [23:0] cfg_ff,   nxt_cfg;
    logic        fails_ff, nxt_fails;
    logic        cstate_ff, nxt_cstate;
    logic [IRQ_W-1:0] ist_ff, nxt_ist;
    logic [IRQ_W-1:0] imask_ff, nxt_imask;
    logic [31:0] rdata_ff, nxt_rdata;

    // Accepted message state
    logic [31:0] act_ff, nxt_act;
    logic [15:0] vlim_ff, nxt_vlim;
    logic [63:0] stat_ff;
    logic [63:0] stat_nxt;

    // Bus strobes, accept and the event vector
    logic        ap_valid;
    logic        wr_en;
    logic        accept;
    logic        unsupported;
    logic [IRQ_W-1:0] ev;

    // Word read mux shared by the read path
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = '0;
        unique case (a)
            A_CTRL:  begin
                v[C_FAILS]  = fails_ff;
                v[C_CONFIG] = cstate_ff;
            end
            A_REQ:   v = req_ff;
            A_LIMIT: v = {16'h0000, lim_ff};
            A_CFG:   v = {8'h00, cfg_ff};
            A_ACT:   v = act_ff;
            A_STLO:  v = stat_ff[31:0];
            A_STHI:  v = stat_ff[63:32];
            A_ISTAT: v = {{(32-IRQ_W){1'b0}}, ist_ff};
            A_IMASK: v = {{(32-IRQ_W){1'b0}}, imask_ff};
            default: v = '0;
        endcase
        return v;
    endfunction

    // Data phase write that hits one register address
    function automatic logic wr_hit(input logic [7:0] a);
        logic hit;
        hit = wr_en && (ap_addr_ff == a);
        return hit;
    endfunction

    // Request word decoder
    srw_req_decode u_dec (
        .rq (rq.dec)
    );

    // Status user data encoder, zeroed in fail-safe or configuration state
    srw_stat_encode u_enc (
        .status_core (status_core),
        .modulating  (modulating),
        .safe_speed  (safe_speed),
        .zero_all    (fails_ff | cstate_ff),
        .status_data (stat_nxt)
    );

    // The slave never stretches a transfer and always answers OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;

    // Stored request word and limit feed the decoder
    assign rq.req_word   = req_ff;
    assign rq.limit_word = lim_ff;

    // Address phase qualification and data phase write strobe
    assign ap_valid = hsel & htrans[1] & hready;
    assign wr_en    = ap_wr_ff;
    assign accept   = wr_hit(A_CTRL) & hwdata[C_ACCEPT];
    assign unsupported = |(rq.fn_req & ~cfg_ff);

    // Bus capture next state
    always_comb begin
        nxt_ap_wr   = ap_valid & hwrite;
        nxt_ap_addr = ap_valid ? haddr[7:0] : ap_addr_ff;
        nxt_rdata   = rdata_ff;
        if (ap_valid && !hwrite) begin
            nxt_rdata = rd_mux(haddr[7:0]);
        end
    end

    // Register the address phase and the read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_ff   <= 1'b0;
            ap_addr_ff <= 8'h00;
            rdata_ff   <= 32'h00000000;
        end else begin
            ap_wr_ff   <= nxt_ap_wr;
            ap_addr_ff <= nxt_ap_addr;
            rdata_ff   <= nxt_rdata;
        end
    end

    // Software register writes
    always_comb begin
        nxt_req    = req_ff;
        nxt_lim    = lim_ff;
        nxt_cfg    = cfg_ff;
        nxt_fails  = fails_ff;
        nxt_cstate = cstate_ff;
        nxt_imask  = imask_ff;
        if (wr_en) begin
            unique case (ap_addr_ff)
                A_CTRL: begin
                    nxt_fails  = hwdata[C_FAILS];
                    nxt_cstate = hwdata[C_CONFIG];
                end
                A_REQ:   nxt_req   = hwdata;
                A_LIMIT: nxt_lim   = hwdata[15:0];
                A_CFG:   nxt_cfg   = hwdata[FN_W-1:0];
                A_IMASK: nxt_imask = hwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Register the writable software state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_ff    <= 32'h00000000;
            lim_ff    <= 16'h0000;
            cfg_ff    <= CFG_RST;
            fails_ff  <= 1'b0;
            cstate_ff <= 1'b0;
            imask_ff  <= 3'h0;
        end else begin
            req_ff    <= nxt_req;
            lim_ff    <= nxt_lim;
            cfg_ff    <= nxt_cfg;
            fails_ff  <= nxt_fails;
            cstate_ff <= nxt_cstate;
            imask_ff  <= nxt_imask;
        end
    end

    // Latch decoded requests only when a message is accepted
    always_comb begin
        nxt_act  = act_ff;
        nxt_vlim = vlim_ff;
        if (accept) begin
            nxt_act = {rq.pos_unscaled, rq.neg_unscaled, rq.safe_out,
                       rq.fn_req | (req_ff[FN_W-1:0] & ~FN_MASK &
                                    ~RSV_MASK[FN_W-1:0])};
            if (unsupported) begin
                nxt_act[RQ_ESTOP] = 1'b1;
            end
            // Limit is taken only together with a variable limit request
            if (rq.fn_req[RQ_VAR]) begin
                nxt_vlim = rq.limit;
            end
        end
    end

    // Register the latched requests and the variable limit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_ff  <= 32'h00000000;
            vlim_ff <= 16'h0000;
        end else begin
            act_ff  <= nxt_act;
            vlim_ff <= nxt_vlim;
        end
    end

    // Status user data is registered every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_ff <= 64'h0000000000000000;
        end else begin
            stat_ff <= stat_nxt;
        end
    end

    // Sticky events, write one to clear, a new event wins over clear
    assign ev[I_ACCEPT] = accept;
    assign ev[I_CFGF]   = accept & unsupported;
    assign ev[I_RSV]    = accept & rq.rsv_hit;

    // Clear by writing ones, then merge the new events
    always_comb begin
        nxt_ist = ist_ff;
        if (wr_hit(A_ISTAT)) begin
            nxt_ist = ist_ff & ~hwdata[IRQ_W-1:0];
        end
        nxt_ist = nxt_ist | ev;
    end

    // Hold the interrupt status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ist_ff <= 3'h0;
        end else begin
            ist_ff <= nxt_ist;
        end
    end

    // Level interrupt and sticky configuration fault
    assign irq = |(ist_ff & imask_ff);
    assign config_fault = ist_ff[I_CFGF];

    // Decoded request outputs from the accepted message
    assign speed_limit_a_req      = act_ff[RQ_SPD_A];
    assign speed_limit_b_req      = act_ff[RQ_SPD_B];
    assign controlled_stop_req    = act_ff[RQ_CSTOP];
    assign emergency_stop_req     = act_ff[RQ_ESTOP];
    assign start_prevention_req   = act_ff[RQ_STARTP];
    assign torque_off_req         = act_ff[RQ_TOFF];
    assign neg_direction_lock_req = act_ff[RQ_NEG_DIR];
    assign pos_direction_lock_req = act_ff[RQ_POS_DIR];
    assign speed_limit_c_req      = act_ff[RQ_SPD_C];
    assign speed_limit_d_req      = act_ff[RQ_SPD_D];
    assign variable_limit_req     = act_ff[RQ_VAR];
    assign function_end_ack       = act_ff[RQ_ACK];
    assign speed_monitor_a_req    = act_ff[RQ_MON_A];
    assign speed_monitor_b_req    = act_ff[RQ_MON_B];
    assign speed_monitor_c_req    = act_ff[RQ_MON_C];
    assign speed_monitor_d_req    = act_ff[RQ_MON_D];
    assign safe_out_ctrl = act_ff[RQ_OUT_LSB +: SAFE_OUT_N];
    assign neg_unscaled  = act_ff[RQ_NEG_SCL];
    assign pos_unscaled  = act_ff[RQ_POS_SCL];
    assign variable_limit = vlim_ff;
    assign status_data    = stat_ff;
endmodule

/* File: tb/srw_decoder_props.sv */
`timescale 1ns/1ps
module srw_decoder_props
    import srw_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [47:0] status_core,
    input wire logic        modulating,
    input wire logic [15:0] safe_speed,
    input wire logic        torque_off_req,
    input wire logic        emergency_stop_req,
    input wire logic        variable_limit_req,
    input wire logic [15:0] variable_limit,
    input wire logic [5:0]  safe_out_ctrl,
    input wire logic        config_fault,
    input wire logic [63:0] status_data
);
    logic        wr_ff, nxt_wr;
    logic [7:0]  adr_ff, nxt_adr;
    logic [31:0] req_ff, nxt_req;
    logic [15:0] lim_ff, nxt_lim;
    logic [23:0] cfg_ff, nxt_cfg;
    logic        acc, frc;
    logic [23:0] held;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Shadow copies of request, limit and configuration writes
    always_comb begin
        nxt_wr  = hsel && htrans[1] && hready && hwrite;
        nxt_adr = haddr[7:0];
        nxt_req = req_ff;
        nxt_lim = lim_ff;
        nxt_cfg = cfg_ff;
        if (wr_ff && adr_ff == A_REQ) nxt_req = hwdata;
        if (wr_ff && adr_ff == A_LIMIT) nxt_lim = hwdata[15:0];
        if (wr_ff && adr_ff == A_CFG) nxt_cfg = hwdata[23:0];
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff  <= 1'b0;
            adr_ff <= 8'h00;
            req_ff <= 32'h0;
            lim_ff <= 16'h0;
            cfg_ff <= CFG_RST;
        end else begin
            wr_ff  <= nxt_wr;
            adr_ff <= nxt_adr;
            req_ff <= nxt_req;
            lim_ff <= nxt_lim;
            cfg_ff <= nxt_cfg;
        end
    end
    // Accept strobe, unconfigured function, outputs that must hold
    assign acc  = wr_ff && adr_ff == A_CTRL && hwdata[C_ACCEPT];
    assign frc  = |(req_ff[23:0] & FN_MASK & ~cfg_ff);
    assign held = {torque_off_req, variable_limit_req, variable_limit,
                   safe_out_ctrl};
    property p_toff; acc |=> torque_off_req == $past(req_ff[RQ_TOFF]);
    endproperty
    a_toff: assert property (p_toff) else $error("torque off");
    property p_out; acc |=> safe_out_ctrl == $past(req_ff[29:24]); endproperty
    a_out: assert property (p_out) else $error("safe outputs");
    property p_lim; acc && req_ff[RQ_VAR] |=> variable_limit_req &&
        variable_limit == {$past(lim_ff[7:0]), $past(lim_ff[15:8])};
    endproperty
    a_lim: assert property (p_lim) else $error("limit");
    property p_frc; acc && frc |=> emergency_stop_req && config_fault;
    endproperty
    a_frc: assert property (p_frc) else $error("forced stop");
    property p_hold; !acc |=> $stable(held); endproperty
    a_hold: assert property (p_hold) else $error("output moved");
    property p_mod; status_data != 64'h0 |-> status_data[47] ==
        $past(modulating); endproperty
    a_mod: assert property (p_mod) else $error("modulating");
    property p_spd; status_data != 64'h0 |-> status_data[63:48] ==
        {$past(safe_speed[7:0]), $past(safe_speed[15:8])}; endproperty
    a_spd: assert property (p_spd) else $error("safe speed");
    property p_zero; $past(modulating) && !status_data[47] |->
        status_data == 64'h0; endproperty
    a_zero: assert property (p_zero) else $error("not zeroed");
    property p_core; status_data != 64'h0 |-> status_data[46:4] ==
        $past(status_core[46:4]) && status_data[1:0] ==
        $past(status_core[1:0]); endproperty
    a_core: assert property (p_core) else $error("status octets");
    property p_rsv; status_core[3:2] != 2'h0 |=> status_data[3:2] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved status");
    c_frc: cover property (acc && frc);
    c_var: cover property (acc && req_ff[RQ_VAR]);
    c_zero: cover property (modulating && status_data == 64'h0);
endmodule
bind srw_decoder_top srw_decoder_props u_props (.*);

/* File: tb/srw_host_model.sv */
`timescale 1ns/1ps
module srw_host_model
    import srw_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    logic [31:0] q;
    // Idle bus at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end
    // Single word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // One safety message: request word, limit, then accept
    task automatic send_msg(input logic [31:0] req, input logic [15:0] lim,
                            input logic clean);
        xfer(1'b1, A_REQ, clean ? req & ~RSV_MASK : req, q);
        xfer(1'b1, A_LIMIT, {16'h0, lim[7:0], lim[15:8]}, q);
        xfer(1'b1, A_CTRL, 32'h1, q);
    endtask
    // Status reader that drops reserved bits of octet 0
    task automatic read_status(output logic [63:0] s);
        xfer(1'b0, A_STHI, 32'h0, s[63:32]);
        xfer(1'b0, A_STLO, 32'h0, s[31:0]);
        s[7:0] = s[7:0] & ~ST0_RSV;
    endtask
endmodule

/* File: tb/tb_safety_request_word_decoder.sv */
`timescale 1ns/1ps
module tb_safety_request_word_decoder
    import srw_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic        modulating, config_fault, neg_unscaled, pos_unscaled;
    logic        speed_limit_a_req, speed_limit_b_req, speed_limit_c_req;
    logic        speed_limit_d_req, controlled_stop_req, emergency_stop_req;
    logic        start_prevention_req, torque_off_req, function_end_ack;
    logic        neg_direction_lock_req, pos_direction_lock_req;
    logic        speed_monitor_a_req, speed_monitor_b_req;
    logic        speed_monitor_c_req, speed_monitor_d_req, variable_limit_req;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [5:0]  safe_out_ctrl;
    logic [15:0] safe_speed, variable_limit, exp_lim;
    logic [31:0] haddr, hwdata, hrdata, got, q;
    logic [47:0] status_core;
    logic [63:0] status_data, sv;
    int          n_errors, checks_done;
    srw_decoder_top uut (.*, .hready(hreadyout));
    srw_host_model host (.*, .hready(hreadyout));
    // Decoded outputs packed back into request word positions
    assign got = {pos_unscaled, neg_unscaled, safe_out_ctrl,
        speed_monitor_a_req, speed_monitor_b_req, speed_monitor_c_req,
        speed_monitor_d_req, 1'b0, function_end_ack, 1'b0,
        variable_limit_req, speed_limit_c_req, speed_limit_d_req, 4'h0,
        pos_direction_lock_req, neg_direction_lock_req, torque_off_req,
        start_prevention_req, emergency_stop_req, controlled_stop_req,
        2'h0, speed_limit_a_req, speed_limit_b_req};
    always #5 hclk = ~hclk;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        check(q, e);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #50000;
        n_errors++;
        complete_run();
    end
    initial begin
        hclk        = 1'b0;
        hresetn     = 1'b0;
        status_core = 48'h0;
        modulating  = 1'b0;
        safe_speed  = 16'h0;
        exp_lim     = 16'h0;
        n_errors    = 0;
        checks_done = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        check(got, 32'h0);
        rc(A_CFG, 32'h00F1C3F3);
        wr(A_IMASK, 32'h2);
        // Walk one request bit at a time
        for (int i = 0; i < 32; i++) begin
            host.send_msg(32'h1 << i, 16'h8000 | 16'(i), 1'b1);
            if (i == RQ_VAR) exp_lim = 16'h8000 | 16'(i);
            @(negedge hclk);
            check(got, (32'h1 << i) & ~RSV_MASK);
            check(variable_limit, exp_lim);
        end
        check(irq, 1'b0);
        wr(A_REQ, 32'h80);
        @(negedge hclk);
        check(got, 32'h80000000);
        // Unconfigured torque off forces emergency stop and a fault
        wr(A_CFG, 32'h00F1C373);
        host.send_msg(32'h80, 16'h0, 1'b1);
        @(negedge hclk);
        check(got, 32'hA0);
        check({irq, config_fault}, 2'h3);
        rc(A_ACT, 32'h000000A0);
        rc(A_ISTAT, 32'h3);
        wr(A_ISTAT, 32'h7);
        rc(A_ISTAT, 32'h0);
        check(irq, 1'b0);
        wr(A_CFG, 32'h00F1C3F3);
        // Reserved bits flagged but never latched
        host.send_msg(RSV_MASK | 32'h1, 16'h0, 1'b0);
        @(negedge hclk);
        check(got, 32'h1);
        rc(A_ISTAT, 32'h5);
        wr(8'h3C, 32'hFFFFFFFF);
        rc(8'h3C, 32'h0);
        check({hresp, hreadyout}, 2'h1);
        // Status encoding from drive inputs
        @(posedge hclk);
        status_core <= 48'h0123_4567_89AF;
        modulating  <= 1'b1;
        safe_speed  <= 16'hFEDC;
        repeat (2) @(negedge hclk);
        check(status_data, 64'hDCFE_8123_4567_89A3);
        host.read_status(sv);
        check(sv, 64'hDCFE_8123_4567_89A3);
        @(posedge hclk);
        modulating  <= 1'b0;
        status_core <= 48'h8123_4567_89AF;
        repeat (2) @(negedge hclk);
        check(status_data, 64'hDCFE_0123_4567_89A3);
        @(posedge hclk);
        modulating <= 1'b1;
        // Fail-safe, then configuration state, zero the status
        for (int k = 1; k < 3; k++) begin
            wr(A_CTRL, 32'h1 << k);
            rc(A_CTRL, 32'h1 << k);
            repeat (2) @(negedge hclk);
            check(status_data, 64'h0);
        end
        wr(A_CTRL, 32'h0);
        repeat (2) @(negedge hclk);
        check(status_data, 64'hDCFE_8123_4567_89A3);
        complete_run();
    end
endmodule
